// *** core/burst_sram_pkg.sv ***
// Shared constants for the two-word burst DDR SRAM device model
package burst_sram_pkg;
  localparam int ORG_X8 = 8;
  localparam int ORG_X18 = 18;
  localparam int ORG_X36 = 36;
  localparam int LANE_W_NIBBLE = 4;
  localparam int LANE_W_BYTE = 9;
  localparam int LANE_COUNT = 4;
  localparam int DEFAULT_ADDR_W = 8;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int SYNC_DEPTH = 3;
  localparam logic ENABLE_OFF_N = 1'b1;
  localparam logic DRIVE_ON_N = 1'b0;
  localparam logic BURST_FLIP = 1'b1;
endpackage : burst_sram_pkg

// *** core/pin_sync3.sv ***
// Three-stage pin synchroniser with agreement filter and rise detection
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  wire [WIDTH-1:0] level_next = (agree & s3_reg) | (~agree & level);

  // Stage one only feeds stage two, so metastability cannot reach logic
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level <= '0;
      rise <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
      rise <= level_next & ~level;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// *** core/burst_sram_device.sv ***
// Two-word burst DDR SRAM with shared data bus, modelled on one system clock
// Behaviour
// - Load low, read_not_write low at K rise: write; word one at K, two at K#
// - Load low, read_not_write high at K rise: read; word one at C#, two at next C
// - Write words are captured on rises of both K and K#
// - Reads launch on output-clock rises, or on K pair rises when C and C# held high
// - Load strobe and read_not_write are sampled only at the rise of K
// - Data outputs stay in high impedance through power-up
// - In x18, lane enable 0 gates bits 0-8, enable 1 gates bits 9-17
// - Both lane enables high writes nothing; both low writes all bits
// - Lane enables apply per beat and may differ between burst beats
// - In x36, lane enables 2 and 3 gate bits 18-26 and 27-35
// - In x8, nibble enables gate bits 0-3 and 4-7
// - Second burst word uses the loaded address with its lowest bit inverted
`timescale 1ns/10ps
`default_nettype none
module burst_sram_device #(
  parameter int ORG = burst_sram_pkg::ORG_X18,
  parameter int ADDR_W = burst_sram_pkg::DEFAULT_ADDR_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic INPUT_CLOCK,
  input wire logic INPUT_CLOCK_N,
  input wire logic OUTPUT_CLOCK,
  input wire logic OUTPUT_CLOCK_N,
  input wire logic LOAD_STROBE_N,
  input wire logic READ_NOT_WRITE,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic LANE_WRITE_ENABLE0_N,
  input wire logic LANE_WRITE_ENABLE1_N,
  input wire logic LANE_WRITE_ENABLE2_N,
  input wire logic LANE_WRITE_ENABLE3_N,
  input wire logic NIBBLE_WRITE_ENABLE0_N,
  input wire logic NIBBLE_WRITE_ENABLE1_N,
  input wire logic [ORG-1:0] DQ_IN,
  output logic [ORG-1:0] DQ_OUT,
  output logic DQ_OE_N
);
  localparam int DATA_W = ORG;
  localparam int LANE_W = (ORG == burst_sram_pkg::ORG_X8) ?
    burst_sram_pkg::LANE_W_NIBBLE : burst_sram_pkg::LANE_W_BYTE;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int NL = burst_sram_pkg::LANE_COUNT;
  // Positions inside the synchroniser bus
  localparam int P_K = 0;
  localparam int P_KN = 1;
  localparam int P_C = 2;
  localparam int P_CN = 3;
  localparam int P_LD = 4;
  localparam int P_RW = 5;
  localparam int P_EN = 6;
  localparam int P_AD = P_EN + NL;
  localparam int P_DQ = P_AD + ADDR_W;
  localparam int SYNC_W = P_DQ + DATA_W;

  typedef enum logic [0:0] {RD_IDLE, RD_SECOND} rd_state_t;

  // Lane that owns a data bit in the chosen organisation
  function automatic int lane_of(input int bit_idx);
    lane_of = bit_idx / LANE_W;
  endfunction : lane_of

  logic [DATA_W-1:0] mem [DEPTH];

  // Nibble enables take the place of lane enables in the x8 organisation
  wire [NL-1:0] en_pins = (ORG == burst_sram_pkg::ORG_X8) ?
    {{(NL-2){burst_sram_pkg::ENABLE_OFF_N}}, NIBBLE_WRITE_ENABLE1_N,
     NIBBLE_WRITE_ENABLE0_N} :
    {LANE_WRITE_ENABLE3_N, LANE_WRITE_ENABLE2_N, LANE_WRITE_ENABLE1_N,
     LANE_WRITE_ENABLE0_N};

  // Every pin passes the same three stages, so data stays aligned with its edge
  wire [SYNC_W-1:0] pins_raw = {DQ_IN, ADDRESS, en_pins, READ_NOT_WRITE, LOAD_STROBE_N,
    OUTPUT_CLOCK_N, OUTPUT_CLOCK, INPUT_CLOCK_N, INPUT_CLOCK};
  wire [SYNC_W-1:0] pins_lvl;
  wire [SYNC_W-1:0] pins_rise;

  pin_sync3 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .pin_in(pins_raw),
    .level(pins_lvl),
    .rise(pins_rise)
  );

  wire k_rise = pins_rise[P_K];
  wire kn_rise = pins_rise[P_KN];
  wire c_rise = pins_rise[P_C];
  wire cn_rise = pins_rise[P_CN];
  wire load_n = pins_lvl[P_LD];
  wire rd_not_wr = pins_lvl[P_RW];
  wire [NL-1:0] en_s = pins_lvl[P_AD-1:P_EN];
  wire [ADDR_W-1:0] addr_s = pins_lvl[P_DQ-1:P_AD];
  wire [DATA_W-1:0] dq_s = pins_lvl[SYNC_W-1:P_DQ];

  // Control sampled only at the K rise
  wire load_wr = k_rise & ~load_n & ~rd_not_wr;
  wire load_rd = k_rise & ~load_n & rd_not_wr;

  // Output clocks held high hand launching over to the K pair
  wire out_held = pins_lvl[P_C] & pins_lvl[P_CN];
  wire launch_a = out_held ? k_rise : c_rise;
  wire launch_b = out_held ? kn_rise : cn_rise;

  // Per-bit write mask from the lane enables of the current beat
  wire [DATA_W-1:0] wr_mask;
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_mask
      assign wr_mask[gi] = ~en_s[lane_of(gi)];
    end
  endgenerate

  logic wr_second_reg;
  logic wr_second_next;
  logic [ADDR_W-1:0] wr_addr2_reg;
  logic [ADDR_W-1:0] wr_addr2_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic [ADDR_W-1:0] rd_addr2_reg;
  logic [ADDR_W-1:0] rd_addr2_next;
  rd_state_t rd_state_reg;
  rd_state_t rd_state_next;
  logic [DATA_W-1:0] dq_next;
  logic oe_n_next;

  // Second beat of a write lands at the K# rise after the loading K rise
  wire beat2 = kn_rise & wr_second_reg;
  wire wr_fire = load_wr | beat2;
  wire [ADDR_W-1:0] wr_addr = beat2 ? wr_addr2_reg : addr_s;
  wire [ADDR_W-1:0] addr_flip = addr_s ^ ADDR_W'(burst_sram_pkg::BURST_FLIP);
  wire [DATA_W-1:0] wr_merged = (mem[wr_addr] & ~wr_mask) | (dq_s & wr_mask);

  always_comb begin
    wr_second_next = wr_second_reg;
    wr_addr2_next = wr_addr2_reg;
    if (beat2) begin
      wr_second_next = 1'b0;
    end
    if (load_wr) begin
      wr_second_next = 1'b1;
      wr_addr2_next = addr_flip;
    end
  end

  // Read launch: first word on the launch_b rise, second on the next launch_a rise
  always_comb begin
    rd_pend_next = rd_pend_reg;
    rd_addr_next = rd_addr_reg;
    rd_addr2_next = rd_addr2_reg;
    rd_state_next = rd_state_reg;
    dq_next = DQ_OUT;
    oe_n_next = DQ_OE_N;
    if (launch_a && rd_state_reg == RD_SECOND) begin
      dq_next = mem[rd_addr2_reg];
      rd_state_next = RD_IDLE;
    end
    if (launch_b) begin
      if (rd_pend_reg) begin
        dq_next = mem[rd_addr_reg];
        oe_n_next = burst_sram_pkg::DRIVE_ON_N;
        rd_addr2_next = rd_addr_reg ^ ADDR_W'(burst_sram_pkg::BURST_FLIP);
        rd_state_next = RD_SECOND;
        rd_pend_next = 1'b0;
      end else begin
        oe_n_next = ~burst_sram_pkg::DRIVE_ON_N;
      end
    end
    // A new load in the same cycle as a launch wins over the clear
    if (load_rd) begin
      rd_pend_next = 1'b1;
      rd_addr_next = addr_s;
    end
  end

  // Memory keeps no reset; contents are undefined until written
  always_ff @(posedge CLOCK) begin
    if (wr_fire) begin
      mem[wr_addr] <= wr_merged;
    end
  end

  // With no clock edges nothing below advances, so pins keep their state
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_second_reg <= 1'b0;
      wr_addr2_reg <= '0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      rd_addr2_reg <= '0;
      rd_state_reg <= RD_IDLE;
      DQ_OUT <= '0;
      DQ_OE_N <= ~burst_sram_pkg::DRIVE_ON_N;
    end else begin
      wr_second_reg <= wr_second_next;
      wr_addr2_reg <= wr_addr2_next;
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      rd_addr2_reg <= rd_addr2_next;
      rd_state_reg <= rd_state_next;
      DQ_OUT <= dq_next;
      DQ_OE_N <= oe_n_next;
    end
  end

  // Checks
  sequence s_write_load;
    load_wr ##1 wr_second_reg;
  endsequence

  sequence s_read_launch;
    launch_b && rd_pend_reg ##1 !DQ_OE_N;
  endsequence

  property p_write_first;
    @(posedge CLOCK) disable iff (RST)
      load_wr |-> wr_fire && wr_addr == addr_s ##1 wr_second_reg;
  endproperty
  a_write_first: assert property (p_write_first)
    else $error("write load did not store word one and arm word two");

  property p_write_second;
    @(posedge CLOCK) disable iff (RST)
      s_write_load ##0 (!load_wr)[*1] ##[0:300] beat2 |->
        wr_fire && wr_addr == wr_addr2_reg ##1 !wr_second_reg;
  endproperty
  a_write_second: assert property (p_write_second)
    else $error("second write beat not taken at K# rise");

  property p_burst_flip;
    @(posedge CLOCK) disable iff (RST)
      load_wr |=> wr_addr2_reg[0] != $past(addr_s[0]) &&
        wr_addr2_reg[ADDR_W-1:1] == $past(addr_s[ADDR_W-1:1]);
  endproperty
  a_burst_flip: assert property (p_burst_flip)
    else $error("second burst address is not the low bit inverted");

  property p_read_drive;
    @(posedge CLOCK) disable iff (RST)
      launch_b && rd_pend_reg |=> !DQ_OE_N && DQ_OUT == mem[$past(rd_addr_reg)]
        && rd_state_reg == RD_SECOND;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("first read word not driven at launch rise");

  property p_read_second;
    @(posedge CLOCK) disable iff (RST)
      s_read_launch ##0 (!launch_a && !launch_b)[*1] ##[0:300]
        (launch_a && rd_state_reg == RD_SECOND) |=>
        !DQ_OE_N && rd_state_reg == RD_IDLE && DQ_OUT == mem[$past(rd_addr2_reg)];
  endproperty
  a_read_second: assert property (p_read_second)
    else $error("second read word not launched on next launch_a rise");

  property p_held_clocks;
    @(posedge CLOCK) disable iff (RST)
      out_held && kn_rise && rd_pend_reg |=> !DQ_OE_N && rd_state_reg == RD_SECOND;
  endproperty
  a_held_clocks: assert property (p_held_clocks)
    else $error("held output clocks did not hand launch to K pair");

  property p_sample_at_k;
    @(posedge CLOCK) disable iff (RST)
      $rose(rd_pend_reg) || $rose(wr_second_reg) |-> $past(k_rise) && !$past(load_n);
  endproperty
  a_sample_at_k: assert property (p_sample_at_k)
    else $error("command taken away from a K rise");

  property p_reset_hiz;
    @(posedge CLOCK) RST |=> DQ_OE_N;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz)
    else $error("data pins driven during reset");

  property p_lane_mask;
    @(posedge CLOCK) disable iff (RST)
      wr_fire |-> wr_mask[0] == !en_s[0] && wr_mask[DATA_W-1] == !en_s[lane_of(DATA_W-1)];
  endproperty
  a_lane_mask: assert property (p_lane_mask)
    else $error("lane mask does not follow the beat enables");

  property p_mask_none;
    @(posedge CLOCK) disable iff (RST)
      wr_fire && &en_s |-> wr_mask == '0 && wr_merged == mem[wr_addr];
  endproperty
  a_mask_none: assert property (p_mask_none)
    else $error("all enables high still changed memory");

  property p_nop_release;
    @(posedge CLOCK) disable iff (RST)
      launch_b && !rd_pend_reg |=> DQ_OE_N;
  endproperty
  a_nop_release: assert property (p_nop_release)
    else $error("data pins not released after no operation");

  property p_stopped_hold;
    @(posedge CLOCK) disable iff (RST)
      !launch_a && !launch_b |=> $stable(DQ_OUT) && $stable(DQ_OE_N);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("outputs changed without a launch edge");
endmodule : burst_sram_device
`default_nettype wire

// *** testbench/ctl_model.sv ***
// Memory controller model: input and output clocks, commands and write data
`timescale 1ns/10ps
`default_nettype none
module ctl_model (
  input wire logic clk,
  input wire logic [17:0] dq_out,
  input wire logic oe_n,
  output logic k,
  output logic kn,
  output logic c,
  output logic cn,
  output logic ld_n,
  output logic rw,
  output logic [7:0] addr,
  output logic [1:0] be_n,
  output logic [17:0] dq_in
);
  logic [17:0] drv;
  logic hold_c;
  // Released bus shows the inverse of the last value, never a stale copy
  assign dq_in = (oe_n == burst_sram_pkg::DRIVE_ON_N) ? dq_out : drv;
  initial begin
    {k, kn, c, cn, rw, hold_c} = 6'h0;
    ld_n = 1'b1;
    addr = 8'h0;
    be_n = 2'h3;
    drv = 18'h0;
  end
  // One link period of eight system cycles; inputs held two cycles either side
  task automatic period(input logic l1, input logic l2, input logic r, input logic [7:0] a,
      input logic [17:0] d1, input logic [1:0] m1, input logic [17:0] d2, input logic [1:0] m2);
    @(posedge clk);
    ld_n <= l1;
    rw <= r;
    addr <= a;
    be_n <= m1;
    drv <= (!l1 && !r) ? d1 : ~drv;
    repeat (2) @(posedge clk);
    k <= 1'b1;
    kn <= 1'b0;
    c <= 1'b1;
    cn <= hold_c;
    repeat (2) @(posedge clk);
    ld_n <= l2;
    be_n <= m2;
    drv <= (!l1 && !r) ? d2 : ~drv;
    repeat (2) @(posedge clk);
    k <= 1'b0;
    kn <= 1'b1;
    c <= hold_c;
    cn <= 1'b1;
    @(posedge clk);
  endtask : period
  task automatic halt;
    @(posedge clk);
    k <= 1'b0;
    kn <= 1'b0;
    c <= hold_c;
    cn <= hold_c;
  endtask : halt
  task automatic set_hold(input logic v);
    @(posedge clk);
    hold_c <= v;
    c <= v;
    cn <= v;
  endtask : set_hold
endmodule : ctl_model
`default_nettype wire

// *** testbench/ddr_burst2_sram_bus_protocol_bench.sv ***
// Self-checking bench for the two-word burst SRAM device
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ddr_burst2_sram_bus_protocol_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic k, kn, c, cn, ld_n, rw, oe_n;
  logic [7:0] addr;
  logic [1:0] be_n;
  logic [17:0] dq_in, dq_out;
  int mismatches = 0;
  int compares = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  burst_sram_device dut (.CLOCK(clock), .RST(rst), .INPUT_CLOCK(k), .INPUT_CLOCK_N(kn),
    .OUTPUT_CLOCK(c), .OUTPUT_CLOCK_N(cn), .LOAD_STROBE_N(ld_n), .READ_NOT_WRITE(rw),
    .ADDRESS(addr), .LANE_WRITE_ENABLE0_N(be_n[0]), .LANE_WRITE_ENABLE1_N(be_n[1]),
    .LANE_WRITE_ENABLE2_N(be_n[0]), .LANE_WRITE_ENABLE3_N(be_n[1]),
    .NIBBLE_WRITE_ENABLE0_N(be_n[0]), .NIBBLE_WRITE_ENABLE1_N(be_n[1]),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(oe_n));
  ctl_model ctl (.clk(clock), .dq_out(dq_out), .oe_n(oe_n), .k(k), .kn(kn), .c(c), .cn(cn),
    .ld_n(ld_n), .rw(rw), .addr(addr), .be_n(be_n), .dq_in(dq_in));
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [17:0] d1, input logic [17:0] d2,
      input logic [1:0] m1, input logic [1:0] m2);
    ctl.period(1'b0, 1'b1, 1'b0, a, d1, m1, d2, m2);
  endtask : wr
  // Word one must stand through a clock stop, since nothing launches word two
  task automatic rd(input logic [7:0] a, input logic [17:0] e1, input logic [17:0] e2,
      input logic stop);
    ctl.period(1'b0, 1'b1, 1'b1, a, 18'h0, 2'h3, 18'h0, 2'h3);
    if (stop) begin
      ctl.halt();
      repeat (20) @(posedge clock);
      #1 `CHK(oe_n, 1'b0)
      `CHK(dq_out, e1)
    end
    fork
      ctl.period(1'b1, 1'b1, 1'b0, a, 18'h0, 2'h3, 18'h0, 2'h3);
      begin
        repeat (6) @(posedge clock);
        #1 `CHK(oe_n, 1'b0)
        `CHK(dq_out, e1)
        repeat (4) @(posedge clock);
        #1 `CHK(dq_out, e2)
        repeat (4) @(posedge clock);
        #1 `CHK(oe_n, 1'b1)
      end
    join
  endtask : rd
  task automatic t_reset;
    ctl.period(1'b1, 1'b1, 1'b1, 8'h10, 18'h0, 2'h3, 18'h0, 2'h3);
    repeat (6) @(posedge clock);
    #1 `CHK(oe_n, 1'b1)
    `CHK(dq_out, 18'h0)
  endtask : t_reset
  task automatic t_burst;
    wr(8'h10, 18'h3abcd, 18'h01234, 2'h0, 2'h0);
    wr(8'h21, 18'h15555, 18'h2aaaa, 2'h0, 2'h0);
    rd(8'h10, 18'h3abcd, 18'h01234, 1'b0);
    rd(8'h20, 18'h2aaaa, 18'h15555, 1'b0);
  endtask : t_burst
  task automatic t_lanes;
    wr(8'h30, 18'h0, 18'h0, 2'h0, 2'h0);
    wr(8'h30, 18'h3ffff, 18'h3ffff, 2'h2, 2'h1);
    wr(8'h30, 18'h0, 18'h0, 2'h3, 2'h3);
    rd(8'h30, 18'h001ff, 18'h3fe00, 1'b0);
  endtask : t_lanes
  // Strobe low only around the K# rise must not load a write
  task automatic t_strobe;
    ctl.period(1'b1, 1'b0, 1'b0, 8'h30, 18'h0, 2'h0, 18'h0, 2'h0);
    rd(8'h30, 18'h001ff, 18'h3fe00, 1'b1);
  endtask : t_strobe
  task automatic t_hold;
    ctl.set_hold(1'b1);
    rd(8'h10, 18'h3abcd, 18'h01234, 1'b0);
    ctl.set_hold(1'b0);
  endtask : t_hold
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 `CHK(oe_n, 1'b1)
    @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_burst();
    t_lanes();
    t_strobe();
    t_hold();
    conclude();
  end
endmodule : ddr_burst2_sram_bus_protocol_bench
`default_nettype wire
